// ### logic/vjf_ctrl.sv
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module vjf_ctrl
    import vjf_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Scan hub side
    input  wire logic                tck_i,
    input  wire logic                tdi_i,
    input  wire logic [IR_W-1:0]     ir_in_i,
    input  wire logic                vs_cdr_i,
    input  wire logic                vs_sdr_i,
    input  wire logic                vs_udr_i,
    input  wire logic                vs_uir_i,
    output logic                     tdo_o,
    // FIFO side
    output logic                     fifo_tick_o,
    output logic                     fifo_wr_o,
    output logic [DATA_W-1:0]        fifo_wdata_o,
    output logic                     fifo_rd_o,
    input  wire logic [DATA_W-1:0]   fifo_rdata_i,
    input  wire logic                fifo_empty_i,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o
);
    localparam int SW = IR_W + 6;

    function automatic vjf_op_type op_decode(input logic [IR_W-1:0] ir);
        unique case (ir)
            OP_PUSH:  op_decode = VJF_OP_PUSH;
            OP_POP:   op_decode = VJF_OP_POP;
            OP_FLUSH: op_decode = VJF_OP_FLUSH;
            default:  op_decode = VJF_OP_NONE;
        endcase
    endfunction : op_decode

    logic [SW-1:0]     sync_s;
    logic              tck_s, tdi_s, cdr_s, sdr_s, udr_s, uir_s;
    logic [IR_W-1:0]   ir_s;
    logic              tck_d_reg;
    logic              tck_rise, tck_fall;
    vjf_op_type        op;
    logic [DATA_W-1:0] push_sh_reg;
    logic [DATA_W-1:0] push_hold_reg;
    logic [DATA_W-1:0] pop_sh_reg;
    logic              byp_reg;
    logic              wr_pend_reg;
    logic              pop_pend_reg;
    logic              pop_pulse_reg;
    logic              flush_req_reg;
    vjf_fl_type        fl_state_reg;
    logic              fl_start;
    logic [2:0]        div_reg;
    logic [1:0]        ctrl_reg;
    logic [15:0]       count_reg;
    logic              wb_req;
    logic [31:0]       rd_next;

    // Every hub signal crosses as a group so edges stay aligned
    vjf_sync #(
        .W (SW)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({tck_i, tdi_i, vs_cdr_i, vs_sdr_i, vs_udr_i, vs_uir_i,
                 ir_in_i}),
        .q_o   (sync_s)
    );

    assign {tck_s, tdi_s, cdr_s, sdr_s, udr_s, uir_s, ir_s} = sync_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tck_d_reg <= 1'b0;
        end else begin
            tck_d_reg <= tck_s;
        end
    end

    assign tck_rise = tck_s & ~tck_d_reg;
    assign tck_fall = ~tck_s & tck_d_reg;
    assign op       = op_decode(ir_s);
    assign fl_start = tck_fall & uir_s & (op == VJF_OP_FLUSH);

    // FIFO clock rate as an enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 3'h0;
        end else if (div_reg == 3'(FIFO_DIV - 1)) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    assign fifo_tick_o = (div_reg == 3'h0);

    // Push chain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            push_sh_reg <= '0;
        end else if (tck_rise && sdr_s && op == VJF_OP_PUSH) begin
            push_sh_reg <= {tdi_s, push_sh_reg[DATA_W-1:1]};
        end
    end

    // Hold register loads on falling test clock edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            push_hold_reg <= '0;
        end else if (tck_fall && udr_s && op == VJF_OP_PUSH) begin
            push_hold_reg <= push_sh_reg;
        end
    end

    // Write request; a new update wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
        end else if (tck_fall && udr_s && op == VJF_OP_PUSH) begin
            wr_pend_reg <= 1'b1;
        end else if (fifo_tick_o && !fifo_wr_o && ctrl_reg[CTRL_EN]) begin
            wr_pend_reg <= 1'b0;
        end
    end

    // One write, one FIFO period long
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_wr_o    <= 1'b0;
            fifo_wdata_o <= '0;
        end else if (fifo_tick_o) begin
            if (fifo_wr_o) begin
                fifo_wr_o <= 1'b0;
            end else if (wr_pend_reg && ctrl_reg[CTRL_EN]) begin
                fifo_wr_o    <= 1'b1;
                fifo_wdata_o <= push_hold_reg;
            end
        end
    end

    // Pop chain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pop_sh_reg <= '0;
        end else if (tck_rise && op == VJF_OP_POP) begin
            if (cdr_s) begin
                pop_sh_reg <= fifo_rdata_i;
            end else if (sdr_s) begin
                pop_sh_reg <= {tdi_s, pop_sh_reg[DATA_W-1:1]};
            end
        end
    end

    // Bypass bit for flush and unknown codes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            byp_reg <= 1'b0;
        end else if (tck_rise && op != VJF_OP_PUSH && op != VJF_OP_POP) begin
            if (cdr_s) begin
                byp_reg <= 1'b0;
            end else if (sdr_s) begin
                byp_reg <= tdi_s;
            end
        end
    end

    // Scan output mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tdo_o <= 1'b0;
        end else begin
            unique case (op)
                VJF_OP_PUSH: tdo_o <= push_sh_reg[0];
                VJF_OP_POP:  tdo_o <= pop_sh_reg[0];
                VJF_OP_FLUSH,
                VJF_OP_NONE: tdo_o <= byp_reg;
            endcase
        end
    end

    // Pop request on instruction update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pop_pend_reg <= 1'b0;
        end else if (tck_fall && uir_s && op == VJF_OP_POP) begin
            pop_pend_reg <= 1'b1;
        end else if (fifo_tick_o && !pop_pulse_reg && ctrl_reg[CTRL_EN]) begin
            pop_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pop_pulse_reg <= 1'b0;
        end else if (fifo_tick_o) begin
            if (pop_pulse_reg) begin
                pop_pulse_reg <= 1'b0;
            end else if (pop_pend_reg && ctrl_reg[CTRL_EN]) begin
                pop_pulse_reg <= 1'b1;
            end
        end
    end

    // Flush burst
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fl_state_reg <= VJF_FL_IDLE;
        end else begin
            unique case (fl_state_reg)
                VJF_FL_IDLE:
                    if (fl_start) begin
                        fl_state_reg <= VJF_FL_RUN;
                    end
                VJF_FL_RUN:
                    if (!fl_start && fifo_tick_o && fifo_empty_i) begin
                        fl_state_reg <= VJF_FL_IDLE;
                    end
            endcase
        end
    end

    // Request held across reads until empty
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flush_req_reg <= 1'b0;
        end else if (fifo_tick_o) begin
            flush_req_reg <= (fl_state_reg == VJF_FL_RUN) && !fifo_empty_i
                             && ctrl_reg[CTRL_EN];
        end
    end

    assign fifo_rd_o = pop_pulse_reg | flush_req_reg;

    // Wishbone: ack one cycle after the strobe, dropped the next
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
        end else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
                     && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
            ctrl_reg <= wb_dat_i[1:0];
        end
    end

    // Count of writes handed to the FIFO; clear bit restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i || ctrl_reg[CTRL_CLR]) begin
            count_reg <= 16'h0000;
        end else if (fifo_tick_o && !fifo_wr_o && wr_pend_reg
                     && ctrl_reg[CTRL_EN]) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (wb_adr_i)
            ADR_CTRL:  rd_next = {30'h0, ctrl_reg};
            ADR_STAT:  rd_next = {16'h0, push_hold_reg, 1'b0,
                                  wr_pend_reg, pop_pend_reg,
                                  fl_state_reg == VJF_FL_RUN, 1'b0, ir_s};
            ADR_COUNT: rd_next = {16'h0, count_reg};
            default:   rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_next;
        end
    end

    // Assertions
    property p_push_shift;
        @(posedge clk_i) disable iff (rst_i)
        tck_rise && sdr_s && op == VJF_OP_PUSH |=>
            push_sh_reg == {$past(tdi_s), $past(push_sh_reg[DATA_W-1:1])};
    endproperty
    a_push_shift: assert property (p_push_shift)
        else $error("push chain did not shift");

    property p_push_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !(tck_rise && sdr_s && op == VJF_OP_PUSH) |=> $stable(push_sh_reg);
    endproperty
    a_push_quiet: assert property (p_push_quiet)
        else $error("push chain moved outside shift");

    property p_update;
        @(posedge clk_i) disable iff (rst_i)
        tck_fall && udr_s && op == VJF_OP_PUSH |=>
            wr_pend_reg && push_hold_reg == $past(push_sh_reg);
    endproperty
    a_update: assert property (p_update)
        else $error("update did not latch push value");

    property p_wr_width;
        @(posedge clk_i) disable iff (rst_i)
        $rose(fifo_wr_o) |-> fifo_wr_o[*5] ##1 !fifo_wr_o;
    endproperty
    a_wr_width: assert property (p_wr_width)
        else $error("write pulse not one FIFO period");

    property p_wr_data;
        @(posedge clk_i) disable iff (rst_i)
        $rose(fifo_wr_o) |-> fifo_wdata_o == $past(push_hold_reg)
            && $past(wr_pend_reg);
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write without request or wrong data");

    property p_pop_cap;
        @(posedge clk_i) disable iff (rst_i)
        tck_rise && cdr_s && op == VJF_OP_POP |=>
            pop_sh_reg == $past(fifo_rdata_i);
    endproperty
    a_pop_cap: assert property (p_pop_cap)
        else $error("pop chain missed FIFO word");

    property p_pop_tdo;
        @(posedge clk_i) disable iff (rst_i)
        op == VJF_OP_POP |=> tdo_o == $past(pop_sh_reg[0]);
    endproperty
    a_pop_tdo: assert property (p_pop_tdo)
        else $error("scan output not from pop chain");

    property p_pop_pulse;
        @(posedge clk_i) disable iff (rst_i)
        $rose(pop_pulse_reg) |-> pop_pulse_reg[*5] ##1 !pop_pulse_reg;
    endproperty
    a_pop_pulse: assert property (p_pop_pulse)
        else $error("pop pulse not one FIFO period");

    property p_flush_hold;
        @(posedge clk_i) disable iff (rst_i)
        fl_state_reg == VJF_FL_RUN && fifo_tick_o && !fifo_empty_i
            && ctrl_reg[CTRL_EN] |=> fifo_rd_o;
    endproperty
    a_flush_hold: assert property (p_flush_hold)
        else $error("flush dropped read request early");

    property p_flush_end;
        @(posedge clk_i) disable iff (rst_i)
        fl_state_reg == VJF_FL_RUN && fifo_tick_o && fifo_empty_i
            && !fl_start |=> fl_state_reg == VJF_FL_IDLE && !flush_req_reg;
    endproperty
    a_flush_end: assert property (p_flush_end)
        else $error("flush did not stop on empty");

    property p_bypass;
        @(posedge clk_i) disable iff (rst_i)
        tck_rise && sdr_s && !cdr_s && op == VJF_OP_FLUSH |=>
            byp_reg == $past(tdi_s) ##1 tdo_o == $past(byp_reg);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass bit broken under flush");

    c_push:  cover property (@(posedge clk_i) $rose(fifo_wr_o));
    c_pop:   cover property (@(posedge clk_i) $rose(pop_pulse_reg));
    c_flush: cover property (@(posedge clk_i)
        fl_state_reg == VJF_FL_RUN ##1 fl_state_reg == VJF_FL_IDLE);
endmodule : vjf_ctrl

// ### logic/vjf_pkg.sv
// Functional notes
// - Three-bit instruction; one decoder serves both write and read sides.
// - Push instruction writes exactly one value into the FIFO write port.
// - Pop instruction removes exactly one value from the FIFO read port.
// - Flush instruction reads in a burst until the FIFO reports empty.
// - Push chain shifts per test clock only under push with shift-data high.
// - Update-data under push yields a write pulse in the write clock domain.
// - Under pop the pop chain drives scan output and one read pulse issues.
// - Pop chain loads FIFO word on capture-data, shifts out on shift-data.
// - After flush is loaded, read request stays high until FIFO empty.
// - Under flush a one-bit bypass sits between scan input and output.
// - FIFO read and write ports run at 50 MHz.
// - Capture loads on rising test clock; update loads on falling edge.
package vjf_pkg;
    localparam int          IR_W      = 3;
    localparam int          DATA_W    = 8;
    localparam int          CLK_MHZ   = 250;
    localparam int          FIFO_MHZ  = 50;
    localparam int          FIFO_DIV  = CLK_MHZ / FIFO_MHZ;
    localparam logic [2:0]  OP_PUSH   = 3'h1;
    localparam logic [2:0]  OP_POP    = 3'h2;
    localparam logic [2:0]  OP_FLUSH  = 3'h3;
    localparam int          WB_ADR_W  = 4;
    localparam logic [3:0]  ADR_CTRL  = 4'h0;
    localparam logic [3:0]  ADR_STAT  = 4'h4;
    localparam logic [3:0]  ADR_COUNT = 4'h8;
    localparam logic [1:0]  CTRL_RST  = 2'h1;
    localparam int          CTRL_EN   = 0;
    localparam int          CTRL_CLR  = 1;

    typedef enum logic [1:0] {
        VJF_OP_NONE,
        VJF_OP_PUSH,
        VJF_OP_POP,
        VJF_OP_FLUSH
    } vjf_op_type;

    typedef enum logic {
        VJF_FL_IDLE,
        VJF_FL_RUN
    } vjf_fl_type;
endpackage : vjf_pkg

// ### logic/vjf_sync.sv
`timescale 1ns/1ps
module vjf_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // First stage read only by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : vjf_sync

// ### verification/vjf_hub_model.sv
`timescale 1ns/1ps
module vjf_hub_model (
    // Clock
    input  wire logic  clk_i,
    // Scan lines
    input  wire logic  tdo_i,
    output logic       tck_o,
    output logic       tdi_o,
    output logic [2:0] ir_o,
    output logic       cdr_o,
    output logic       sdr_o,
    output logic       udr_o,
    output logic       uir_o
);
    initial begin
        tck_o = 1'h0;
        tdi_o = 1'h0;
        ir_o  = 3'h0;
        cdr_o = 1'h0;
        sdr_o = 1'h0;
        udr_o = 1'h0;
        uir_o = 1'h0;
    end

    // One link period; lines move mid-low so they hold 16 ns round edges
    task automatic pulse(output logic s);
        repeat (4) @(posedge clk_i);
        s = tdo_i;
        tck_o <= 1'h1;
        repeat (8) @(posedge clk_i);
        tck_o <= 1'h0;
        repeat (4) @(posedge clk_i);
    endtask : pulse

    task automatic ir_scan(input logic [2:0] c);
        logic s;
        ir_o  <= c;
        uir_o <= 1'h1;
        pulse(s);
        uir_o <= 1'h0;
        tdi_o <= ~tdi_o;
    endtask : ir_scan

    // Idle period first, as the real state walk leaves time to pop
    task automatic dr_scan(input logic [7:0] d, output logic [7:0] q);
        logic s;
        pulse(s);
        cdr_o <= 1'h1;
        pulse(s);
        cdr_o <= 1'h0;
        sdr_o <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            tdi_o <= d[i];
            pulse(q[i]);
        end
        sdr_o <= 1'h0;
        udr_o <= 1'h1;
        pulse(s);
        udr_o <= 1'h0;
        tdi_o <= ~d[7];
    endtask : dr_scan
endmodule : vjf_hub_model

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
    import vjf_pkg::*;
    logic              clk, rst, tck, tdi, cdr, sdr, udr, uir, tdo;
    logic              tick, wr, rd, ack;
    logic              empty = 1'h1;
    logic              cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [IR_W-1:0]   ir;
    logic [DATA_W-1:0] wdata, w, x, v, scan_word;
    logic [DATA_W-1:0] rdata = 8'h00;
    logic [3:0]        adr = 4'h0;
    logic [31:0]       din = 32'h0, dout, d;
    logic [31:0]       seed = 32'h8C9F;
    logic [7:0]        fq[$], exp_wr[$], sent[$], exp_scan[$];
    logic [2:0]        codes[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    int                fails = 0, checked = 0, wr_cnt = 0, rd_cnt = 0, n;
    event              scan_done;

    vjf_ctrl u_vjf_ctrl (
        .clk_i(clk), .rst_i(rst), .tck_i(tck), .tdi_i(tdi), .ir_in_i(ir),
        .vs_cdr_i(cdr), .vs_sdr_i(sdr), .vs_udr_i(udr), .vs_uir_i(uir),
        .tdo_o(tdo), .fifo_tick_o(tick), .fifo_wr_o(wr),
        .fifo_wdata_o(wdata), .fifo_rd_o(rd), .fifo_rdata_i(rdata),
        .fifo_empty_i(empty), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(din),
        .wb_dat_o(dout), .wb_ack_o(ack)
    );

    vjf_hub_model hub (
        .clk_i(clk), .tdo_i(tdo), .tck_o(tck), .tdi_o(tdi), .ir_o(ir),
        .cdr_o(cdr), .sdr_o(sdr), .udr_o(udr), .uir_o(uir)
    );

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic wb(logic wen, logic [3:0] a, logic [31:0] wd,
                      output logic [31:0] q);
        int k;
        k = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we  <= wen;
        adr <= a;
        din <= wd;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'h1 && k < 50);
        if (ack !== 1'h1) begin
            check("wb_ack", 1, 0);
            conclude();
        end
        q = dout;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk);
    endtask : wb

    task automatic wait_wr(int m);
        for (int k = 0; k < 300 && wr_cnt < m; k++) @(posedge clk);
        if (wr_cnt < m) begin
            check("wr_cnt", m, wr_cnt);
            conclude();
        end
    endtask : wait_wr

    task automatic push(logic [7:0] pv);
        exp_wr.push_back(pv);
        sent.push_back(pv);
        hub.ir_scan(OP_PUSH);
        hub.dr_scan(pv, w);
    endtask : push

    task automatic scan(logic [2:0] c, logic [7:0] e, logic [7:0] di);
        exp_scan.push_back(e);
        hub.ir_scan(c);
        hub.dr_scan(di, w);
        scan_word = w;
        -> scan_done;
    endtask : scan

    // FIFO with registered output; reads on empty are ignored
    always @(posedge clk) begin
        if (tick === 1'h1 && wr === 1'h1) begin
            fq.push_back(wdata);
            wr_cnt++;
            if (exp_wr.size() == 0)
                check("fifo_wr", 0, 1);
            else
                check("fifo_wdata", 32'(exp_wr.pop_front()), 32'(wdata));
        end
        if (tick === 1'h1 && rd === 1'h1 && fq.size() > 0) begin
            rdata <= fq.pop_front();
            rd_cnt++;
        end
        empty <= (fq.size() == 0);
    end

    always @(scan_done) begin
        check("scan_word", 32'(exp_scan.pop_front()), 32'(scan_word));
    end

    initial begin
        rst = 1'h1;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        repeat (3) @(posedge clk);
        wb(1'h0, ADR_CTRL, 0, d);
        check("ctrl", 32'(CTRL_RST), d);
        wb(1'h0, ADR_COUNT, 0, d);
        check("count", 0, d);
        wb(1'h0, 4'hC, 0, d);
        check("unmapped", 0, d);
        for (int i = 1; i <= 4; i++) begin
            v = rnd();
            push(v);
            wait_wr(i);
        end
        wb(1'h0, ADR_COUNT, 0, d);
        check("count", 4, d);
        wb(1'h0, ADR_STAT, 0, d);
        check("last_push", 32'(v), 32'(d[15:8]));
        scan(OP_POP, sent.pop_front(), rnd());
        scan(OP_POP, sent.pop_front(), rnd());
        // Random pop shifts must not disturb the push hold register
        wb(1'h0, ADR_STAT, 0, d);
        check("push_kept", 32'(v), 32'(d[15:8]));
        for (int i = 0; i < 5; i++) begin
            x = rnd();
            scan(codes[i], {x[6:0], 1'h0}, x);
        end
        check("wr_cnt", 4, wr_cnt);
        check("rd_cnt", 2, rd_cnt);
        // Disabled: the write must wait, not vanish
        wb(1'h1, ADR_CTRL, 0, d);
        push(rnd());
        repeat (40) @(posedge clk);
        check("wr_held", 4, wr_cnt);
        wb(1'h1, ADR_CTRL, 1, d);
        wait_wr(5);
        n = rd_cnt;
        hub.ir_scan(OP_FLUSH);
        for (int k = 0; k < 2000 && !(fq.size() == 0 && rd === 1'h0); k++)
            @(posedge clk);
        check("fifo_left", 0, fq.size());
        check("rd_low", 0, 32'(rd));
        check("flush_reads", 3, rd_cnt - n);
        sent.delete();
        x = rnd();
        scan(OP_FLUSH, {x[6:0], 1'h0}, x);
        // Let the compare process take the last scan word first
        @(posedge clk);
        conclude();
    end
endmodule : tb
